/* mtp_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the transmit port
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes:   definitions only
`ifndef MTP_CFG_SVH
`define MTP_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MTP_REG_CTRL       8'h00
`define MTP_REG_PACKET_COMPRESS_SIGNAL      8'h04
`define MTP_REG_TXDATA     8'h08
`define MTP_REG_TXLAST     8'h0C
`define MTP_REG_STATUS     8'h10
`define MTP_REG_MGCMD      8'h14
`define MTP_REG_MGCTRL     8'h18
`define MTP_REG_MGRD       8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MTP_CTRL_MODE10    0
`define MTP_CTRL_LOOP      1
`define MTP_CTRL_FERR      2
`define MTP_PACKET_COMPRESS_SIGNAL_POL      0
`define MTP_PACKET_COMPRESS_SIGNAL_MATCH    1
`define MTP_MGCTRL_RD      0
`define MTP_ST_BUSY        0
`define MTP_ST_COL         1
`define MTP_ST_HOLD        2
`define MTP_ST_MGBUSY      3
`define MTP_ST_PACKET_COMPRESS_SIGNAL       4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MTP_CTRL_RST       3'h0
`define MTP_PACKET_COMPRESS_SIGNAL_RST      2'h3

// ----------------------------------------------------------------
// frame constants and timing
// ----------------------------------------------------------------
`define MTP_PRE_BYTE       8'h55
`define MTP_SFD_BYTE       8'hD5
`define MTP_CRC_INIT       32'hFFFFFFFF
`define MTP_CRC_POLY       32'hEDB88320
`define MTP_CLK_NS         25
`define MTP_MDC_HALF_NS    200
`define MTP_MG_BITS        32
`define MTP_MG_RD_RELEASE  14
`define MTP_MG_RD_DATA     16

`endif

/* mtp_pkg.sv */
// Purpose: shared types of the transmit port
// Assumes: nothing
// Notes:   constants live in mtp_cfg.svh
package mtp_pkg;

  typedef enum logic [3:0] {
    MTP_S_IDLE = 4'b0001,
    MTP_S_PRE  = 4'b0010,
    MTP_S_DATA = 4'b0100,
    MTP_S_CRC  = 4'b1000
  } mtp_txst_e;

  typedef logic [31:0] mtp_word_t;

endpackage

/* mtp_sync2.sv */
// Purpose: two-flop level synchroniser, also used as a reset release synchroniser
// Assumes: d is stable long enough to be seen by the destination clock
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module mtp_sync2 #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= {W{RST_VAL}};
      q      <= {W{RST_VAL}};
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* mtp_top.sv */
// Purpose: transmit side of the media independent port with 10 Mbit/s pin reuse,
//          packet compression output and management data line
// Assumes: tx_clk comes from the PHY; receive logic supplies address-match events
// Notes:   software feeds frame words over Wishbone; preamble, SFD and CRC are added here
`timescale 1ns/1ps
`include "mtp_cfg.svh"

// Notes on behaviour
// - nibble and transmit enable change only on the rising edge of the PHY transmit clock.
// - bit 0 carries the first bit on the wire, low nibble of a byte first, high nibble next.
// - transmit enable is high exactly over the valid nibbles from preamble through CRC.
// - transmit error is driven on the transmit clock and marks the frame for corruption.
// - in 10 Mbit/s mode bit 0 is the serial line and transmit enable marks data ready.
// - in 10 Mbit/s mode bit 1 follows the loop-back control bit.
// - in 10 Mbit/s mode packet compression asserts right after the destination address.
// - software picks match or mismatch as trigger and the output polarity.
// - the device drives the management clock as the reference for management data.
// - the PHY drives management data on reads, the device drives it on writes.
module mtp_top #(
  parameter int AW = 8
) (
  // system clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // receive-side address match events
  input  wire logic        rx_da_done,
  input  wire logic        rx_cam_match,
  input  wire logic        rx_frame_end,
  // transmit link to the PHY
  input  wire logic        tx_clk,
  output logic      [3:0]  tx_nibble_port0,
  output logic             tx_en,
  output logic             tx_err,
  input  wire logic        collision_in,
  output logic             packet_compress_out,
  // management line
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);

  localparam int MDC_HALF = (`MTP_MDC_HALF_NS + `MTP_CLK_NS - 1) / `MTP_CLK_NS;

  function automatic mtp_pkg::mtp_word_t crc_byte(input mtp_pkg::mtp_word_t c,
                                                  input logic [7:0] d);
    mtp_pkg::mtp_word_t r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MTP_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // system domain: register bus
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic [1:0]  pcfg_r;
  logic        mg_rd_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        req_tgl_r;
  logic [31:0] hold_data_r;
  logic [1:0]  hold_len_r;
  logic        hold_last_r;
  logic        col_sticky_r;
  logic        col_prev_r;
  logic        pc_act_r;
  logic        pc_out_r;
  logic        pc_act_nxt;
  logic        mg_busy_r;
  logic [2:0]  sys_s;
  logic        mdi_s;
  logic [1:0]  sel_len;
  logic        wb_req;
  logic        is_tx_wr;
  logic        mg_wr;
  logic        hold_busy;
  logic        wb_take;
  logic        wr_take;
  logic [15:0] mg_rdata_r;

  assign wb_req    = wb_cyc_i && wb_stb_i;
  assign hold_busy = req_tgl_r != sys_s[0];
  assign is_tx_wr  = wb_we_i && (wb_adr_i == AW'(`MTP_REG_TXDATA) ||
                                 wb_adr_i == AW'(`MTP_REG_TXLAST));
  assign mg_wr     = wb_we_i && wb_adr_i == AW'(`MTP_REG_MGCMD);
  // a write that cannot be taken yet holds off the ack instead of being dropped
  assign wb_take   = wb_req && !ack_r && !(is_tx_wr && hold_busy) && !(mg_wr && mg_busy_r);
  assign wr_take   = wb_take && wb_we_i;
  assign sel_len   = wb_sel_i[3] ? 2'h3 : wb_sel_i[2] ? 2'h2 : wb_sel_i[1] ? 2'h1 : 2'h0;
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ack_r <= 1'b0;
    else
      ack_r <= wb_take;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r  <= `MTP_CTRL_RST;
      pcfg_r  <= `MTP_PACKET_COMPRESS_SIGNAL_RST;
      mg_rd_r <= 1'b0;
    end
    else if (wr_take)
    begin
      if (wb_adr_i == AW'(`MTP_REG_CTRL))
        ctrl_r <= wb_dat_i[2:0];
      if (wb_adr_i == AW'(`MTP_REG_PACKET_COMPRESS_SIGNAL))
        pcfg_r <= wb_dat_i[1:0];
      if (wb_adr_i == AW'(`MTP_REG_MGCTRL))
        mg_rd_r <= wb_dat_i[`MTP_MGCTRL_RD];
    end
  end

  // unmapped addresses still ack and read as zero
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      dat_r <= 32'h0;
    else if (wb_take && !wb_we_i)
    begin
      dat_r <= 32'h0;
      unique case (wb_adr_i)
        AW'(`MTP_REG_CTRL):   dat_r[2:0] <= ctrl_r;
        AW'(`MTP_REG_PACKET_COMPRESS_SIGNAL):  dat_r[1:0] <= pcfg_r;
        AW'(`MTP_REG_MGCTRL): dat_r[`MTP_MGCTRL_RD] <= mg_rd_r;
        AW'(`MTP_REG_MGRD):   dat_r[15:0] <= mg_rdata_r;
        AW'(`MTP_REG_STATUS):
        begin
          dat_r[`MTP_ST_BUSY]   <= sys_s[2];
          dat_r[`MTP_ST_COL]    <= col_sticky_r;
          dat_r[`MTP_ST_HOLD]   <= hold_busy;
          dat_r[`MTP_ST_MGBUSY] <= mg_busy_r;
          dat_r[`MTP_ST_PACKET_COMPRESS_SIGNAL]  <= pc_act_r;
        end
        default:              dat_r <= 32'h0;
      endcase
    end
  end

  // word hand-off toward the transmit clock: data stands still while the toggles differ
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      req_tgl_r   <= 1'b0;
      hold_data_r <= 32'h0;
      hold_len_r  <= 2'h0;
      hold_last_r <= 1'b0;
    end
    else if (wr_take && is_tx_wr)
    begin
      req_tgl_r   <= ~req_tgl_r;
      hold_data_r <= wb_dat_i;
      hold_last_r <= wb_adr_i == AW'(`MTP_REG_TXLAST);
      hold_len_r  <= (wb_adr_i == AW'(`MTP_REG_TXLAST)) ? sel_len : 2'h3;
    end
  end

  // collision events arrive as toggles; a new event beats a software clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      col_prev_r   <= 1'b0;
      col_sticky_r <= 1'b0;
    end
    else
    begin
      col_prev_r <= sys_s[1];
      if (sys_s[1] != col_prev_r)
        col_sticky_r <= 1'b1;
      else if (wr_take && wb_adr_i == AW'(`MTP_REG_STATUS) && wb_dat_i[`MTP_ST_COL])
        col_sticky_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // packet compression
  // ----------------------------------------------------------------
  always_comb
  begin
    pc_act_nxt = pc_act_r;
    if (rx_frame_end)
      pc_act_nxt = 1'b0;
    if (ctrl_r[`MTP_CTRL_MODE10] && rx_da_done &&
        rx_cam_match == pcfg_r[`MTP_PACKET_COMPRESS_SIGNAL_MATCH])
      pc_act_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_act_r <= 1'b0;
      pc_out_r <= 1'b0;
    end
    else
    begin
      pc_act_r <= pc_act_nxt;
      pc_out_r <= pcfg_r[`MTP_PACKET_COMPRESS_SIGNAL_POL] ? pc_act_nxt : ~pc_act_nxt;
    end
  end

  assign packet_compress_out = pc_out_r;

  // ----------------------------------------------------------------
  // management line
  // ----------------------------------------------------------------
  logic [31:0] mg_sh_r;
  logic [5:0]  mg_bit_r;
  logic [7:0]  mg_div_r;
  logic        mdc_r;
  logic        mdo_r;
  logic        mdoe_r;
  logic        mg_edge;

  assign mg_edge = mg_busy_r && mg_div_r == 8'(MDC_HALF - 1);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mdc_r    <= 1'b0;
      mg_div_r <= 8'h0;
    end
    else if (!mg_busy_r)
    begin
      mdc_r    <= 1'b0;
      mg_div_r <= 8'h0;
    end
    else if (mg_edge)
    begin
      mdc_r    <= ~mdc_r;
      mg_div_r <= 8'h0;
    end
    else
      mg_div_r <= mg_div_r + 8'h1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mg_busy_r  <= 1'b0;
      mg_sh_r    <= 32'h0;
      mg_bit_r   <= 6'h0;
      mdo_r      <= 1'b0;
      mdoe_r     <= 1'b0;
      mg_rdata_r <= 16'h0;
    end
    else if (!mg_busy_r)
    begin
      mdoe_r <= 1'b0;
      if (wr_take && mg_wr)
      begin
        mg_busy_r <= 1'b1;
        mg_bit_r  <= 6'h0;
        mdo_r     <= wb_dat_i[31];
        mg_sh_r   <= {wb_dat_i[30:0], 1'b0};
        mdoe_r    <= 1'b1;
      end
    end
    else if (mg_edge && !mdc_r)
    begin
      // rising management clock: the PHY samples here, read data is taken here
      if (mg_rd_r && mg_bit_r >= 6'(`MTP_MG_RD_DATA))
        mg_rdata_r <= {mg_rdata_r[14:0], mdi_s};
      mg_bit_r <= mg_bit_r + 6'h1;
    end
    else if (mg_edge && mdc_r)
    begin
      // end on the fall after the last rise so the final clock high keeps its full width
      if (mg_bit_r == 6'(`MTP_MG_BITS))
        mg_busy_r <= 1'b0;
      mdo_r   <= mg_sh_r[31];
      mg_sh_r <= {mg_sh_r[30:0], 1'b0};
      mdoe_r  <= !(mg_rd_r && mg_bit_r >= 6'(`MTP_MG_RD_RELEASE));
    end
  end

  assign mdc     = mdc_r;
  assign mdio_o  = mdo_r;
  assign mdio_oe = mdoe_r;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic       tx_rst_n;
  logic [3:0] tx_s;
  logic       col_s;
  logic       ack_tgl_r;
  logic       col_tgl_r;
  logic       txen_r;

  mtp_sync2 #(.W(1), .RST_VAL(1'b0)) u_tx_rst (
    .clk   (tx_clk),
    .rst_n (rstn),
    .d     (1'b1),
    .q     (tx_rst_n)
  );

  mtp_sync2 #(.W(4), .RST_VAL(1'b0)) u_tx_cfg (
    .clk   (tx_clk),
    .rst_n (tx_rst_n),
    .d     ({req_tgl_r, ctrl_r}),
    .q     (tx_s)
  );

  mtp_sync2 #(.W(1), .RST_VAL(1'b0)) u_tx_col (
    .clk   (tx_clk),
    .rst_n (tx_rst_n),
    .d     (collision_in),
    .q     (col_s)
  );

  mtp_sync2 #(.W(3), .RST_VAL(1'b0)) u_sys_in (
    .clk   (clk_sys),
    .rst_n (rstn),
    .d     ({txen_r, col_tgl_r, ack_tgl_r}),
    .q     (sys_s)
  );

  mtp_sync2 #(.W(1), .RST_VAL(1'b0)) u_mdi (
    .clk   (clk_sys),
    .rst_n (rstn),
    .d     (mdio_i),
    .q     (mdi_s)
  );

  // ----------------------------------------------------------------
  // transmit clock domain
  // ----------------------------------------------------------------
  mtp_pkg::mtp_txst_e st_r;
  mtp_pkg::mtp_txst_e st_nxt;
  logic [31:0] wbuf_r;
  logic [1:0]  wlen_r;
  logic        wlast_r;
  logic        wfull_r;
  logic [1:0]  bi_r;
  logic [7:0]  sh_r;
  logic [2:0]  cnt_r;
  logic [2:0]  idx_r;
  logic [31:0] crc_r;
  logic        endf_r;
  logic        uerr_r;
  logic        col_d_r;
  logic [3:0]  txd_r;
  logic        txer_r;
  logic        m10;
  logic        bdone;
  logic        take;
  logic        under;
  logic [7:0]  byte_nxt;
  logic [31:0] crc_inv;
  logic [7:0]  wbyte;

  assign m10     = tx_s[`MTP_CTRL_MODE10];
  assign bdone   = st_r != mtp_pkg::MTP_S_IDLE && cnt_r == (m10 ? 3'h7 : 3'h1);
  assign crc_inv = ~crc_r;
  assign wbyte   = wbuf_r[{bi_r, 3'h0} +: 8];

  always_comb
  begin
    st_nxt   = st_r;
    byte_nxt = sh_r;
    take     = 1'b0;
    under    = 1'b0;
    unique case (st_r)
      mtp_pkg::MTP_S_IDLE:
        if (wfull_r)
        begin
          st_nxt   = mtp_pkg::MTP_S_PRE;
          byte_nxt = `MTP_PRE_BYTE;
        end
      mtp_pkg::MTP_S_PRE:
        if (bdone)
        begin
          if (idx_r == 3'h7)
          begin
            st_nxt   = mtp_pkg::MTP_S_DATA;
            take     = wfull_r;
            under    = !wfull_r;
            byte_nxt = wfull_r ? wbyte : 8'h00;
          end
          else
            byte_nxt = (idx_r == 3'h6) ? `MTP_SFD_BYTE : `MTP_PRE_BYTE;
        end
      mtp_pkg::MTP_S_DATA:
        if (bdone)
        begin
          if (endf_r)
          begin
            st_nxt   = mtp_pkg::MTP_S_CRC;
            byte_nxt = crc_inv[7:0];
          end
          else
          begin
            take     = wfull_r;
            under    = !wfull_r;
            byte_nxt = wfull_r ? wbyte : 8'h00;
          end
        end
      mtp_pkg::MTP_S_CRC:
        if (bdone)
        begin
          if (idx_r == 3'h3)
            st_nxt = mtp_pkg::MTP_S_IDLE;
          else
            byte_nxt = crc_inv[{idx_r[1:0] + 2'h1, 3'h0} +: 8];
        end
    endcase
  end

  always_ff @(posedge tx_clk or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      wbuf_r    <= 32'h0;
      wlen_r    <= 2'h0;
      wlast_r   <= 1'b0;
      wfull_r   <= 1'b0;
      bi_r      <= 2'h0;
      ack_tgl_r <= 1'b0;
    end
    else if (!wfull_r && tx_s[3] != ack_tgl_r)
    begin
      wbuf_r    <= hold_data_r;
      wlen_r    <= hold_len_r;
      wlast_r   <= hold_last_r;
      wfull_r   <= 1'b1;
      ack_tgl_r <= tx_s[3];
    end
    else if (take)
    begin
      bi_r <= (bi_r == wlen_r) ? 2'h0 : bi_r + 2'h1;
      if (bi_r == wlen_r)
        wfull_r <= 1'b0;
    end
  end

  always_ff @(posedge tx_clk or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      st_r   <= mtp_pkg::MTP_S_IDLE;
      sh_r   <= 8'h00;
      cnt_r  <= 3'h0;
      idx_r  <= 3'h0;
      crc_r  <= `MTP_CRC_INIT;
      endf_r <= 1'b0;
      uerr_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == mtp_pkg::MTP_S_IDLE || bdone)
      begin
        sh_r  <= byte_nxt;
        cnt_r <= 3'h0;
        idx_r <= (st_nxt != st_r) ? 3'h0 : idx_r + 3'h1;
      end
      else
      begin
        sh_r  <= m10 ? {1'b0, sh_r[7:1]} : {4'h0, sh_r[7:4]};
        cnt_r <= cnt_r + 3'h1;
      end
      if (st_r == mtp_pkg::MTP_S_IDLE)
        crc_r <= `MTP_CRC_INIT;
      else if (take)
        crc_r <= crc_byte(crc_r, wbyte);
      if (take)
        endf_r <= wlast_r && bi_r == wlen_r;
      if (take || under)
        uerr_r <= under;
    end
  end

  // registered pin drive, launched on the rising transmit clock edge
  always_ff @(posedge tx_clk or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      txd_r  <= 4'h0;
      txen_r <= 1'b0;
      txer_r <= 1'b0;
    end
    else
    begin
      if (m10)
        txd_r <= {2'b00, tx_s[`MTP_CTRL_LOOP],
                  st_r != mtp_pkg::MTP_S_IDLE && sh_r[0]};
      else
        txd_r <= (st_r != mtp_pkg::MTP_S_IDLE) ? sh_r[3:0] : 4'h0;
      txen_r <= st_r != mtp_pkg::MTP_S_IDLE;
      // in 10 Mbit/s mode this pin is held low; packet compression has its own output
      txer_r <= !m10 && st_r != mtp_pkg::MTP_S_IDLE &&
                (uerr_r || tx_s[`MTP_CTRL_FERR]);
    end
  end

  always_ff @(posedge tx_clk or negedge tx_rst_n)
  begin
    if (!tx_rst_n)
    begin
      col_d_r   <= 1'b0;
      col_tgl_r <= 1'b0;
    end
    else
    begin
      col_d_r <= col_s;
      if (col_s && !col_d_r && st_r != mtp_pkg::MTP_S_IDLE)
        col_tgl_r <= ~col_tgl_r;
    end
  end

  assign tx_nibble_port0 = txd_r;
  assign tx_en           = txen_r;
  assign tx_err          = txer_r;

endmodule

/* mtp_top_asserts.sv */
// Purpose: concurrent checks on the transmit port pins and bus
// Assumes: bound to mtp_top, sees its ports only
// Notes:   mode bits are internal, so link checks key on pin patterns
`timescale 1ns/1ps
module mtp_top_asserts (
  // system side
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       rx_da_done,
  input wire logic       rx_frame_end,
  input wire logic       packet_compress_out,
  // link side
  input wire logic       tx_clk,
  input wire logic [3:0] tx_nibble_port0,
  input wire logic       tx_en,
  input wire logic       tx_err,
  // management side
  input wire logic       mdc,
  input wire logic       mdio_o,
  input wire logic       mdio_oe
);
  a_ack_one_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_req: assert property (@(posedge clk_sys) disable iff (!rstn)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  // an mii preamble is the only frame start with nibble 5, serial mode keeps bits 3:2 low
  a_pre_to_sfd: assert property (@(posedge tx_clk) disable iff (!rstn)
    $rose(tx_en) && tx_nibble_port0 == 4'h5 |-> ##15 tx_nibble_port0 == 4'hD)
    else $error("start delimiter not at nibble 16");
  a_en_min_len: assert property (@(posedge tx_clk) disable iff (!rstn)
    $rose(tx_en) |-> tx_en [*8]) else $error("transmit enable too short");
  a_err_in_frame: assert property (@(posedge tx_clk) disable iff (!rstn)
    tx_err |-> tx_en) else $error("transmit error outside a frame");
  a_packet_compress_signal_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(packet_compress_out) |-> $past(rx_da_done || rx_frame_end ||
    (wb_ack_o && wb_we_i)) || $past(wb_ack_o && wb_we_i, 2))
    else $error("compression output moved without cause");
  a_mdc_half_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(mdc) |-> mdc [*8] ##1 !mdc) else $error("management clock half period wrong");
  a_mdio_at_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(mdio_o) |-> !mdc) else $error("management data moved while clock high");
  a_oe_stable_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    mdc |-> $stable(mdio_oe)) else $error("line direction moved while clock high");
endmodule

bind mtp_top mtp_top_asserts mtp_top_asserts_inst (.*);

/* mtp_phy_model.sv */
// Purpose: behavioural PHY at the far side of the transmit port
// Assumes: transmit clock made by the bench, runs free
// Notes:   management line has a pull-up; reads are decoded from the opcode
`timescale 1ns/1ps
module mtp_phy_model (
  // transmit pins
  input wire logic        tx_clk,
  input wire logic [3:0]  tx_nibble_port0,
  input wire logic        tx_en,
  input wire logic        tx_err,
  input wire logic        mode10,
  input wire logic        col_req,
  output logic            collision_in,
  // management pins
  input wire logic        mdc,
  input wire logic        mdio_o,
  input wire logic        mdio_oe,
  input wire logic [15:0] phy_rd,
  output logic            mdio_i
);
  logic [7:0]  sh = 8'h00;
  logic [7:0]  q[$];
  logic [31:0] mg_bits = 32'h0;
  logic        was_en = 1'b0, drv = 1'b0, bitv = 1'b0, rd_op = 1'b0;
  int          nb = 0, frames = 0, errs = 0, loop1 = 0, loop0 = 0, mcnt = 0, clash = 0;

  assign collision_in = col_req;
  // a released line floats up to the pull-up level
  assign mdio_i = mdio_oe ? mdio_o : (drv ? bitv : 1'b1);

  always @(posedge tx_clk)
  begin
    if (tx_en === 1'b1)
    begin
      if (tx_err === 1'b1) errs++;
      if (mode10)
      begin
        sh = {tx_nibble_port0[0], sh[7:1]};
        nb += 1;
        if (tx_nibble_port0[1]) loop1++;
        else loop0++;
      end
      else
      begin
        sh = {tx_nibble_port0, sh[7:4]};
        nb += 4;
      end
      if (nb == 8) q.push_back(sh);
      if (nb == 8) nb = 0;
    end
    else if (was_en) frames++;
    if (tx_en !== 1'b1) nb = 0;
    was_en = (tx_en === 1'b1);
  end

  always @(posedge mdio_oe) mcnt = 0;
  // answer changes after a rising edge, held for the whole next bit
  always @(posedge mdc)
  begin
    if (mdio_oe) mg_bits = {mg_bits[30:0], mdio_o};
    if (mdio_oe && drv) clash++;
    mcnt++;
    if (mcnt == 4) rd_op = (mg_bits[1:0] == 2'b10);
    drv = rd_op && mcnt >= 15 && mcnt <= 31;
    bitv = (mcnt >= 16 && mcnt <= 31) ? phy_rd[31-mcnt] : 1'b0;
  end
endmodule

/* tb.sv */
// Purpose: self-checking bench of the transmit port
// Assumes: seed 24, both clocks free running
// Notes:   expected frames are built here, preamble and CRC included
`timescale 1ns/1ps
`include "mtp_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb;
  logic        clk_sys = 0, rstn = 0, tx_clk = 0, mode10 = 0, col_req = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic        rx_da_done = 0, rx_cam_match = 0, rx_frame_end = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, tx_nibble_port0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, w;
  logic [15:0] phy_rd = 16'h0;
  logic        wb_ack_o, tx_en, tx_err, collision_in, packet_compress_out;
  logic        mdc, mdio_i, mdio_o, mdio_oe;
  logic [7:0]  exp_q[$];
  int          err_count = 0, cmp_count = 0, seed = 24;

  always #12.5 clk_sys = ~clk_sys;
  always #24 tx_clk = ~tx_clk;

  mtp_top mtp_top_inst (.*);
  mtp_phy_model mtp_phy_model_inst (.*);

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 4000);
    `CHK(wb_ack_o, 1'b1)
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c;
    c = `MTP_CRC_INIT;
    foreach (b[i])
    begin
      c = c ^ {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `MTP_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic send_frame(input int n, input logic e);
    logic [7:0]  b[$];
    logic [31:0] c;
    int          i, f0;
    exp_q = {};
    repeat (7) exp_q.push_back(`MTP_PRE_BYTE);
    exp_q.push_back(`MTP_SFD_BYTE);
    repeat (n) b.push_back(8'($random(seed)));
    c = crc32(b);
    exp_q = {exp_q, b, c[7:0], c[15:8], c[23:16], c[31:24]};
    mtp_phy_model_inst.q = {};
    mtp_phy_model_inst.errs = 0;
    f0 = mtp_phy_model_inst.frames;
    for (i = 0; i < n; i += 4)
    begin
      w = 32'h0;
      for (int k = 0; k < 4 && i + k < n; k++) w[8*k+:8] = b[i+k];
      if (n - i > 4) wb(1'b1, `MTP_REG_TXDATA, w);
      else wb(1'b1, `MTP_REG_TXLAST, w, 4'((5'h1 << (n - i)) - 1));
    end
    i = 0;
    while (mtp_phy_model_inst.frames == f0 && i < 20000)
    begin
      @(posedge clk_sys);
      i++;
    end
    `CHK(mtp_phy_model_inst.q.size(), exp_q.size())
    foreach (exp_q[k]) `CHK(mtp_phy_model_inst.q[k], exp_q[k])
    `CHK(mtp_phy_model_inst.errs > 0, e)
  endtask

  task automatic rx_evt(input logic cam, input logic fin, input logic e);
    @(posedge clk_sys);
    rx_da_done <= ~fin;
    rx_frame_end <= fin;
    rx_cam_match <= cam;
    @(posedge clk_sys);
    rx_da_done <= 1'b0;
    rx_frame_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(packet_compress_out, e)
  endtask

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #1000000;
    `CHK(1'b0, 1'b1)
    final_report();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge tx_clk);
    wb(1'b0, `MTP_REG_CTRL, 32'h0);
    `CHK(rd[2:0], `MTP_CTRL_RST)
    wb(1'b0, `MTP_REG_PACKET_COMPRESS_SIGNAL, 32'h0);
    `CHK(rd[1:0], `MTP_PACKET_COMPRESS_SIGNAL_RST)
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    // one byte, one exact word, then a random length spanning words
    for (int i = 0; i < 3; i++)
      send_frame(i == 0 ? 1 : (i == 1 ? 4 : 5 + $unsigned($random(seed)) % 8), 1'b0);
    wb(1'b1, `MTP_REG_CTRL, 32'h4);
    send_frame(6, 1'b1);
    for (int lp = 0; lp < 2; lp++)
    begin
      wb(1'b1, `MTP_REG_CTRL, 32'(1 + 2 * lp));
      mode10 <= 1'b1;
      mtp_phy_model_inst.loop1 = 0;
      mtp_phy_model_inst.loop0 = 0;
      send_frame(3 + lp, 1'b0);
      `CHK(mtp_phy_model_inst.loop1 > 0, lp[0])
      `CHK(mtp_phy_model_inst.loop0 > 0, ~lp[0])
    end
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, `MTP_REG_PACKET_COMPRESS_SIGNAL, 32'(c));
      for (int m = 0; m < 2; m++)
      begin
        rx_evt(m[0], 1'b0, (m[0] == c[1]) ? c[0] : ~c[0]);
        rx_evt(1'b0, 1'b1, ~c[0]);
      end
    end
    wb(1'b1, `MTP_REG_CTRL, 32'h0);
    mode10 <= 1'b0;
    wb(1'b1, `MTP_REG_PACKET_COMPRESS_SIGNAL, 32'h3);
    rx_evt(1'b1, 1'b0, 1'b0);
    // collisions are only reported while a frame is on the wire
    fork
      send_frame(2, 1'b0);
      begin
        wait (tx_en === 1'b1);
        @(posedge clk_sys);
        col_req <= 1'b1;
        repeat (3) @(posedge tx_clk);
        col_req <= 1'b0;
      end
    join
    repeat (4) @(posedge tx_clk);
    wb(1'b0, `MTP_REG_STATUS, 32'h0);
    `CHK(rd[`MTP_ST_COL], 1'b1)
    wb(1'b1, `MTP_REG_STATUS, 32'h2);
    wb(1'b0, `MTP_REG_STATUS, 32'h0);
    `CHK(rd[`MTP_ST_COL], 1'b0)
    for (int r = 0; r < 2; r++)
    begin
      phy_rd <= 16'($random(seed));
      w = {2'b01, r ? 2'b10 : 2'b01, 28'($random(seed))};
      wb(1'b1, `MTP_REG_MGCTRL, 32'(r));
      wb(1'b1, `MTP_REG_MGCMD, w);
      rd[`MTP_ST_MGBUSY] = 1'b1;
      for (int n = 0; n < 400 && rd[`MTP_ST_MGBUSY] !== 1'b0; n++)
        wb(1'b0, `MTP_REG_STATUS, 32'h0);
      wb(1'b0, `MTP_REG_MGRD, 32'h0);
      if (r == 0) `CHK(mtp_phy_model_inst.mg_bits, w)
      else `CHK(rd[15:0], phy_rd)
    end
    `CHK(mtp_phy_model_inst.clash, 0)
    final_report();
  end
endmodule
